// ---- src/mpsi_pkg.sv ----
// Constants, register map and carrier types of the MII pin and strap block.
// Assumes a 10 MHz APB clock and an MII clock of 800 ns made from it.
package mpsi_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MII_CLK_PERIOD_NS = 800;
    localparam int unsigned MII_HALF_CYCLES =
        MII_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [2:0] MII_HALF_LAST = 3'(MII_HALF_CYCLES - 1);
    // Two sync stages plus one cycle of margin
    localparam int unsigned STRAP_SETTLE_CYCLES = 3;
    localparam logic [1:0] SETTLE_LAST = 2'(STRAP_SETTLE_CYCLES - 1);

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_ADV = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_TX_DATA = 8'h10;
    localparam logic [7:0] ADDR_RX_DATA = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h20;

    // Field positions
    localparam int unsigned CTRL0_DUPLEX_BIT = 8;
    localparam int unsigned CTRL0_STRAP_A_BIT = 12;
    localparam int unsigned CTRL0_SPEED_BIT = 13;
    localparam int unsigned ADV_SPEED_BIT = 7;
    localparam int unsigned CTRL_IRQ_HIGH_BIT = 0;
    localparam int unsigned CTRL_ACTIVITY_INDICATOR_N_FUNC_BIT = 1;
    localparam int unsigned CTRL_SPEED_INDICATOR_N_FUNC_BIT = 2;
    localparam int unsigned IRQ_TX_NIBBLE = 0;
    localparam int unsigned IRQ_TX_ERROR = 1;
    localparam int unsigned IRQ_RX_SENT = 2;
    localparam int unsigned IRQ_LINE_SIGNAL_DETECT_CHANGE = 3;
    localparam int unsigned IRQ_W = 4;

    // Reset values
    localparam logic [15:0] CTRL0_RESET = 16'h0000;
    localparam logic [15:0] ADV_RESET = 16'h0000;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    // Operating configuration strap codes
    localparam logic [2:0] OPM_NORMAL_CODE = 3'h0;
    localparam logic [2:0] OPM_NORMAL_XOVER_CODE = 3'h2;
    localparam logic [2:0] OPM_B2B_XOVER_CODE = 3'h6;

    typedef enum logic [1:0] {
        OPM_NORMAL,
        OPM_NORMAL_XOVER,
        OPM_B2B_XOVER,
        OPM_RESERVED
    } mpsi_op_mode_t;

    typedef enum logic [1:0] {
        PH_SETTLE,
        PH_CAPTURE,
        PH_RUN
    } mpsi_phase_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [2:0] op_mode;
        logic duplex;
        logic strap_a;
        logic speed;
        logic tree_sel;
    } mpsi_strap_t;

    // Every level that arrives from outside the pclk domain
    typedef struct packed {
        logic rx_clk;
        logic [3:0] rx_data;
        logic rx_dv;
        logic carrier_sense;
        logic act_led;
        logic spd_led;
        logic irq_pin;
        logic tx_en;
        logic [3:0] tx_data;
        logic tx_er;
        logic link_up;
        logic energy;
    } mpsi_pins_t;

    typedef struct packed {
        logic rx_pend;
        logic link_up;
        logic sig_detect;
        logic tree_sel;
        logic speed;
        logic strap_a;
        logic duplex;
        logic [1:0] mode;
        logic [2:0] op_mode;
        logic [2:0] addr;
    } mpsi_status_t;

    typedef struct packed {
        logic err;
        logic [3:0] nibble;
    } mpsi_tx_word_t;

    function automatic mpsi_op_mode_t decode_op_mode(input logic [2:0] code);
        mpsi_op_mode_t m;
        m = OPM_RESERVED;
        case (code)
            OPM_NORMAL_CODE: m = OPM_NORMAL;
            OPM_NORMAL_XOVER_CODE: m = OPM_NORMAL_XOVER;
            OPM_B2B_XOVER_CODE: m = OPM_B2B_XOVER;
            default: m = OPM_RESERVED;
        endcase
        return m;
    endfunction : decode_op_mode

    function automatic logic reg_mapped(input logic [7:0] a);
        return (a == ADDR_CTRL0) || (a == ADDR_ADV) || (a == ADDR_STATUS) ||
            (a == ADDR_CTRL) || (a == ADDR_TX_DATA) ||
            (a == ADDR_RX_DATA) || (a == ADDR_IRQ_STATUS) ||
            (a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
    endfunction : reg_mapped

endpackage : mpsi_pkg

// ---- src/mpsi_sync.sv ----
// Two-stage level synchroniser bank.
// Assumes inputs are levels; pulses shorter than one clock may be lost.
`timescale 1ns/1ns
module mpsi_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : mpsi_sync

// ---- src/mpsi_top.sv ----
// MII pin side of a 10/100 transceiver: strap capture, MII clocks and data,
// LED and interrupt pins, APB register file.
// Assumes pclk at 10 MHz; all pin levels are asynchronous to pclk.
// Operation
// R1: Rx nibble moves with rx clock; valid only while rx_dv.
// R2: Tx nibble taken on tx clock only while tx_en.
// R3: Device drives the tx clock; MAC never does.
// R4: Rx clock driven after reset; its strap is op mode bit 0.
// R5: Rx data bits 3,2,1 strap address bits 0,1,2.
// R6: Rx data bit 0 straps duplex, then drives data.
// R7: Carrier sense straps op mode bit 1, then is driven.
// R8: Activity LED active low, programmable, straps auto-negotiation.
// R9: Speed LED active low, programmable, straps speed.
// R10: Open-drain irq pin, programmable polarity; straps tree mode.
// R11: Low reset input resets the device.
// R12: Signal detect high while line signal is detected.
// R13: MAC without tx error holds that input low.
// R14: Op mode 000 normal, 010 crossover, 110 back-to-back; others reserved.
// R15: Auto-negotiation strap copied into control bit 12.
// R16: Speed strap copied into control bit 13 and advertised speed.
// R17: Duplex strap inverted into control bit 8.
// R18: Strap pins inputs in reset, captured once, then driven.
`timescale 1ns/1ns
module mpsi_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_clk,
    input wire logic tx_en,
    input wire logic [3:0] tx_data,
    input wire logic tx_er,
    input wire logic rx_clk_sense,
    output logic rx_clk,
    output logic rx_clk_oe_n,
    input wire logic [3:0] rx_data_sense,
    output logic [3:0] rx_data,
    output logic rx_data_oe_n,
    input wire logic rx_dv_sense,
    output logic rx_dv,
    output logic rx_dv_oe_n,
    input wire logic carrier_sense_sense,
    output logic carrier_sense,
    output logic carrier_sense_oe_n,
    input wire logic activity_indicator_n_sense,
    output logic activity_indicator_n,
    output logic activity_indicator_n_oe_n,
    input wire logic speed_indicator_n_sense,
    output logic speed_indicator_n,
    output logic speed_indicator_n_oe_n,
    input wire logic irq_out_sense,
    output logic irq_out,
    output logic irq_out_oe_n,
    input wire logic line_link_up,
    input wire logic line_energy,
    output logic line_signal_detect,
    output logic [2:0] strap_station_address,
    output logic irq
);

    mpsi_pkg::mpsi_pins_t pins_raw;
    mpsi_pkg::mpsi_pins_t pins_s;
    logic [$bits(mpsi_pkg::mpsi_pins_t)-1:0] pins_sync_bits;

    mpsi_pkg::mpsi_phase_t phase_ff;
    logic [1:0] settle_cnt_ff;
    mpsi_pkg::mpsi_strap_t strap_ff;
    logic drive_oe_n_ff;

    logic [2:0] div_cnt_ff;
    logic mii_clk_ff;
    logic half_done;
    logic fall_tick;

    logic [15:0] ctrl0_ff;
    logic [15:0] adv_ff;
    logic [2:0] ctrl_ff;
    logic [3:0] irq_status_ff;
    logic [3:0] irq_enable_ff;
    logic [3:0] irq_events;
    logic [3:0] irq_clear;

    mpsi_pkg::mpsi_tx_word_t tx_word_ff;
    logic [3:0] rx_nib_ff;
    logic rx_pend_ff;
    logic [3:0] rx_data_ff;
    logic rx_dv_ff;
    logic carrier_sense_ff;
    logic act_led_n_ff;
    logic spd_led_n_ff;
    logic irq_ff;
    logic irq_pin_ff;
    logic irq_pin_oe_n_ff;
    logic line_signal_detect_ff;

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic apb_setup;
    logic apb_write;
    logic [31:0] rd_data;
    mpsi_pkg::mpsi_status_t status_word;
    logic running;
    logic activity;

    assign pins_raw = '{
        rx_clk: rx_clk_sense,
        rx_data: rx_data_sense,
        rx_dv: rx_dv_sense,
        carrier_sense: carrier_sense_sense,
        act_led: activity_indicator_n_sense,
        spd_led: speed_indicator_n_sense,
        irq_pin: irq_out_sense,
        tx_en: tx_en,
        tx_data: tx_data,
        tx_er: tx_er,
        link_up: line_link_up,
        energy: line_energy
    };

    mpsi_sync #(
        .WIDTH($bits(mpsi_pkg::mpsi_pins_t))
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_raw),
        .sync_out(pins_sync_bits)
    );

    assign pins_s = pins_sync_bits;
    assign running = (phase_ff == mpsi_pkg::PH_RUN);

    // Let synchronisers fill, capture, then drive
    always_ff @(posedge pclk or negedge presetn) // R11
    begin
        if (!presetn)
        begin
            phase_ff <= mpsi_pkg::PH_SETTLE;
            settle_cnt_ff <= 2'h0;
        end
        else
        begin
            case (phase_ff)
                mpsi_pkg::PH_SETTLE:
                begin
                    if (settle_cnt_ff == mpsi_pkg::SETTLE_LAST)
                    begin
                        phase_ff <= mpsi_pkg::PH_CAPTURE;
                    end
                    settle_cnt_ff <= settle_cnt_ff + 2'h1;
                end
                mpsi_pkg::PH_CAPTURE: phase_ff <= mpsi_pkg::PH_RUN;
                mpsi_pkg::PH_RUN: phase_ff <= mpsi_pkg::PH_RUN;
                default: phase_ff <= mpsi_pkg::PH_SETTLE;
            endcase
        end
    end

    // Captured exactly once; drivers enable only after this edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_ff <= '0;
            drive_oe_n_ff <= 1'b1; // R18
        end
        else if (phase_ff == mpsi_pkg::PH_CAPTURE)
        begin
            strap_ff.op_mode <= {pins_s.rx_dv, pins_s.carrier_sense,
                pins_s.rx_clk}; // R4 R7
            strap_ff.addr <= {pins_s.rx_data[1], pins_s.rx_data[2],
                pins_s.rx_data[3]}; // R5
            strap_ff.duplex <= pins_s.rx_data[0]; // R6
            strap_ff.strap_a <= pins_s.act_led; // R8
            strap_ff.speed <= pins_s.spd_led; // R9
            strap_ff.tree_sel <= pins_s.irq_pin; // R10
            drive_oe_n_ff <= 1'b0; // R18
        end
    end

    // One MII clock serves both directions
    assign half_done = running && (div_cnt_ff == mpsi_pkg::MII_HALF_LAST);
    assign fall_tick = half_done && mii_clk_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_ff <= 3'h0;
            mii_clk_ff <= 1'b0;
        end
        else if (!running)
        begin
            div_cnt_ff <= 3'h0;
            mii_clk_ff <= 1'b0;
        end
        else if (half_done)
        begin
            div_cnt_ff <= 3'h0;
            mii_clk_ff <= ~mii_clk_ff; // R3 R4
        end
        else
        begin
            div_cnt_ff <= div_cnt_ff + 3'h1;
        end
    end

    // Sample at the fall, half a period after the MAC moved data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_word_ff <= '0;
        end
        else if (fall_tick && pins_s.tx_en) // R2
        begin
            tx_word_ff.nibble <= pins_s.tx_data; // R2
            tx_word_ff.err <= pins_s.tx_er; // R13
        end
    end

    // One holding nibble; a write while pending is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_pend_ff <= 1'b0;
            rx_nib_ff <= 4'h0;
        end
        else if (apb_write && (paddr == mpsi_pkg::ADDR_RX_DATA) &&
            !rx_pend_ff)
        begin
            rx_pend_ff <= 1'b1;
            rx_nib_ff <= pwdata[3:0];
        end
        else if (fall_tick)
        begin
            rx_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_data_ff <= 4'h0;
            rx_dv_ff <= 1'b0;
        end
        else if (!running)
        begin
            rx_dv_ff <= 1'b0;
        end
        else if (fall_tick)
        begin
            rx_dv_ff <= rx_pend_ff; // R1
            if (rx_pend_ff)
            begin
                rx_data_ff <= rx_nib_ff; // R1
            end
        end
    end

    // Carrier sense, LEDs and signal detect
    assign activity = pins_s.tx_en || rx_dv_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carrier_sense_ff <= 1'b0;
            act_led_n_ff <= 1'b1;
            spd_led_n_ff <= 1'b1;
            line_signal_detect_ff <= 1'b0;
        end
        else
        begin
            carrier_sense_ff <= running && activity; // R7
            line_signal_detect_ff <= pins_s.energy; // R12
            if (ctrl_ff[mpsi_pkg::CTRL_ACTIVITY_INDICATOR_N_FUNC_BIT])
            begin
                act_led_n_ff <= ~(running && activity); // R8
            end
            else
            begin
                act_led_n_ff <= ~(running &&
                    (pins_s.link_up || activity)); // R8
            end
            if (ctrl_ff[mpsi_pkg::CTRL_SPEED_INDICATOR_N_FUNC_BIT])
            begin
                spd_led_n_ff <= ~(running && pins_s.link_up); // R9
            end
            else
            begin
                spd_led_n_ff <= ~(running && pins_s.link_up &&
                    ctrl0_ff[mpsi_pkg::CTRL0_SPEED_BIT]); // R9
            end
        end
    end

    // Hardware set beats a software clear in one cycle
    always_comb
    begin
        irq_events = 4'h0;
        irq_events[mpsi_pkg::IRQ_TX_NIBBLE] = fall_tick && pins_s.tx_en;
        irq_events[mpsi_pkg::IRQ_TX_ERROR] = fall_tick && pins_s.tx_en &&
            pins_s.tx_er;
        irq_events[mpsi_pkg::IRQ_RX_SENT] = fall_tick && rx_pend_ff;
        irq_events[mpsi_pkg::IRQ_LINE_SIGNAL_DETECT_CHANGE] = running &&
            (line_signal_detect_ff != pins_s.energy);
    end

    assign irq_clear = (apb_write && (paddr == mpsi_pkg::ADDR_IRQ_CLEAR)) ?
        pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_ff <= 4'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    // Pull low or release; released during reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pin_ff <= 1'b1;
            irq_pin_oe_n_ff <= 1'b1;
        end
        else if (!running)
        begin
            irq_pin_ff <= 1'b1;
            irq_pin_oe_n_ff <= 1'b1;
        end
        else
        begin
            irq_pin_ff <= ctrl_ff[mpsi_pkg::CTRL_IRQ_HIGH_BIT] ~^ irq_ff;
            irq_pin_oe_n_ff <= ctrl_ff[mpsi_pkg::CTRL_IRQ_HIGH_BIT] ~^
                irq_ff; // R10
        end
    end

    // Register file
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pready_ff && pwrite;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_ff <= mpsi_pkg::CTRL0_RESET;
            adv_ff <= mpsi_pkg::ADV_RESET;
        end
        else if (phase_ff == mpsi_pkg::PH_CAPTURE)
        begin
            ctrl0_ff[mpsi_pkg::CTRL0_STRAP_A_BIT] <= pins_s.act_led; // R15
            ctrl0_ff[mpsi_pkg::CTRL0_SPEED_BIT] <= pins_s.spd_led; // R16
            ctrl0_ff[mpsi_pkg::CTRL0_DUPLEX_BIT] <= ~pins_s.rx_data[0]; // R17
            adv_ff[mpsi_pkg::ADV_SPEED_BIT] <= pins_s.spd_led; // R16
        end
        else if (apb_write && (paddr == mpsi_pkg::ADDR_CTRL0))
        begin
            ctrl0_ff <= pwdata[15:0];
        end
        else if (apb_write && (paddr == mpsi_pkg::ADDR_ADV))
        begin
            adv_ff <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= mpsi_pkg::CTRL_RESET;
            irq_enable_ff <= mpsi_pkg::IRQ_EN_RESET;
        end
        else if (apb_write && (paddr == mpsi_pkg::ADDR_CTRL))
        begin
            ctrl_ff <= pwdata[2:0];
        end
        else if (apb_write && (paddr == mpsi_pkg::ADDR_IRQ_ENABLE))
        begin
            irq_enable_ff <= pwdata[3:0];
        end
    end

    always_comb
    begin
        status_word.rx_pend = rx_pend_ff;
        status_word.link_up = pins_s.link_up;
        status_word.sig_detect = line_signal_detect_ff;
        status_word.tree_sel = strap_ff.tree_sel;
        status_word.speed = strap_ff.speed;
        status_word.strap_a = strap_ff.strap_a;
        status_word.duplex = strap_ff.duplex;
        status_word.mode = mpsi_pkg::decode_op_mode(strap_ff.op_mode); // R14
        status_word.op_mode = strap_ff.op_mode;
        status_word.addr = strap_ff.addr;
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (paddr)
            mpsi_pkg::ADDR_CTRL0: rd_data = {16'h0000, ctrl0_ff};
            mpsi_pkg::ADDR_ADV: rd_data = {16'h0000, adv_ff};
            mpsi_pkg::ADDR_STATUS:
                rd_data = {{(32 - $bits(status_word)){1'b0}}, status_word};
            mpsi_pkg::ADDR_CTRL: rd_data = {29'h0000_0000, ctrl_ff};
            mpsi_pkg::ADDR_TX_DATA:
                rd_data = {{(32 - $bits(tx_word_ff)){1'b0}}, tx_word_ff};
            mpsi_pkg::ADDR_IRQ_STATUS: rd_data = {28'h000_0000, irq_status_ff};
            mpsi_pkg::ADDR_IRQ_ENABLE: rd_data = {28'h000_0000, irq_enable_ff};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // No wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= apb_setup;
            if (apb_setup)
            begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr_ff <= !mpsi_pkg::reg_mapped(paddr);
            end
            else
            begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign tx_clk = mii_clk_ff;
    assign rx_clk = mii_clk_ff;
    assign rx_clk_oe_n = drive_oe_n_ff;
    assign rx_data = rx_data_ff;
    assign rx_data_oe_n = drive_oe_n_ff;
    assign rx_dv = rx_dv_ff;
    assign rx_dv_oe_n = drive_oe_n_ff;
    assign carrier_sense = carrier_sense_ff;
    assign carrier_sense_oe_n = drive_oe_n_ff;
    assign activity_indicator_n = act_led_n_ff;
    assign activity_indicator_n_oe_n = drive_oe_n_ff;
    assign speed_indicator_n = spd_led_n_ff;
    assign speed_indicator_n_oe_n = drive_oe_n_ff;
    assign irq_out = irq_pin_ff;
    assign irq_out_oe_n = irq_pin_oe_n_ff;
    assign line_signal_detect = line_signal_detect_ff;
    assign strap_station_address = strap_ff.addr;
    assign irq = irq_ff;

endmodule : mpsi_top

// ---- testbench/mpsi_top_properties.sv ----
// Concurrent checks on the pin side of the MII strap block.
// Assumes strap levels are held steady from reset through capture.
`timescale 1ns/1ns
module mpsi_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic [3:0] rx_data,
    input wire logic [3:0] rx_data_sense,
    input wire logic rx_data_oe_n,
    input wire logic carrier_sense,
    input wire logic activity_indicator_n,
    input wire logic speed_indicator_n,
    input wire logic irq_out,
    input wire logic irq_out_oe_n,
    input wire logic line_energy,
    input wire logic line_signal_detect,
    input wire logic [2:0] strap_station_address
);
    logic [3:0] sense_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Pin level one edge back
    always_ff @(posedge pclk) sense_q <= rx_data_sense;
    sequence clk_hi4;
        tx_clk [*4] ##1 !tx_clk;
    endsequence
    AST_RX_ON_FALL: assert property ($changed({rx_dv, rx_data})
        |-> $fell(rx_clk)) else $error("rx off fall");
    AST_TXC_HALF: assert property ($rose(tx_clk) |-> clk_hi4)
        else $error("tx clk phase");
    AST_RXC_TXC: assert property (rx_clk == tx_clk)
        else $error("rx clk differs");
    AST_ADDR_CAP: assert property ($fell(rx_data_oe_n)
        |-> strap_station_address == {sense_q[1], sense_q[2], sense_q[3]})
        else $error("addr strap");
    AST_QUIET: assert property (rx_data_oe_n |-> !tx_clk && !rx_dv)
        else $error("early drive");
    AST_LED_OFF: assert property (rx_data_oe_n
        |-> activity_indicator_n && speed_indicator_n)
        else $error("early led");
    AST_IRQ_OD: assert property (irq_out == irq_out_oe_n)
        else $error("irq not od");
    AST_CRS: assert property ($rose(rx_dv) |=> carrier_sense)
        else $error("no crs");
    AST_LINE_SIGNAL_DETECT: assert property ($rose(line_energy)
        |-> ##[1:4] line_signal_detect) else $error("line_signal_detect late");
endmodule : mpsi_props
bind mpsi_top mpsi_props mpsi_props_inst (.*);

// ---- testbench/mpsi_mac.sv ----
// MAC model on the far side of the MII pins.
// Assumes the device makes both clocks; they are sampled on pclk.
`timescale 1ns/1ns
module mpsi_mac (
    input wire logic pclk,
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic rx_dv,
    input wire logic [3:0] rx_data,
    input wire logic go,
    input wire mpsi_pkg::mpsi_tx_word_t word,
    output logic tx_en,
    output logic [3:0] tx_data,
    output logic tx_er,
    output logic [3:0] rx_last,
    output logic [7:0] rx_cnt
);
    logic txc_q;
    logic rxc_q;
    initial
    begin
        {tx_en, tx_data, tx_er, rx_last, rx_cnt} = '0;
        {txc_q, rxc_q} = '0;
    end
    always @(posedge pclk)
    begin
        txc_q <= tx_clk;
        rxc_q <= rx_clk;
        // Idle nibbles toggle so stale data never looks valid
        if (tx_clk && !txc_q)
        begin
            tx_en <= go;
            tx_data <= go ? word.nibble : ~tx_data;
            tx_er <= go && word.err;
        end
        if (rx_clk && !rxc_q && rx_dv)
        begin
            rx_last <= rx_data;
            rx_cnt <= rx_cnt + 8'h01;
        end
    end
endmodule : mpsi_mac

// ---- testbench/mpsi_top_tb_top.sv ----
// Self-checking bench: straps, MII traffic, APB registers, interrupt.
// Assumes pull-ups on the interrupt pin and strap levels driven in reset.
`timescale 1ns/1ns
`define CHK(n, a, b) begin cmp_count++; if ((a) !== (b)) begin \
fail_count++; $display("Error %s exp %0h got %0h", n, a, b); end end
module mpsi_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, go;
    logic [7:0] paddr, c, rx_cnt;
    logic [31:0] pwdata, prdata, r, x;
    logic tx_clk, tx_en, tx_er, rx_clk, rx_clk_oe_n, rx_dv, rx_dv_oe_n;
    logic [3:0] tx_data, rx_data, rx_data_sense, rx_last;
    logic rx_data_oe_n, carrier_sense, carrier_sense_oe_n, irq_out;
    logic activity_indicator_n, activity_indicator_n_oe_n, irq_out_oe_n;
    logic speed_indicator_n, speed_indicator_n_oe_n, line_link_up;
    logic line_energy, line_signal_detect, rx_clk_sense, rx_dv_sense;
    logic carrier_sense_sense, activity_indicator_n_sense, irq_out_sense;
    logic speed_indicator_n_sense;
    logic [2:0] strap_station_address;
    mpsi_pkg::mpsi_strap_t s, t;
    mpsi_pkg::mpsi_tx_word_t w;
    int fail_count, cmp_count, n;
    // Strap levels stand on the pins only while the device is not driving
    assign rx_clk_sense = rx_clk_oe_n ? s.op_mode[0] : rx_clk;
    assign carrier_sense_sense =
        carrier_sense_oe_n ? s.op_mode[1] : carrier_sense;
    assign rx_dv_sense = rx_dv_oe_n ? s.op_mode[2] : rx_dv;
    assign rx_data_sense = rx_data_oe_n ?
        {s.addr[0], s.addr[1], s.addr[2], s.duplex} : rx_data;
    assign activity_indicator_n_sense =
        activity_indicator_n_oe_n ? s.strap_a : activity_indicator_n;
    assign speed_indicator_n_sense =
        speed_indicator_n_oe_n ? s.speed : speed_indicator_n;
    assign irq_out_sense = !irq_out_oe_n ? 1'b0 :
        (rx_data_oe_n ? s.tree_sel : 1'b1);
    mpsi_top mpsi_top_inst (.*);
    mpsi_mac mpsi_mac_inst (.pclk, .tx_clk, .rx_clk, .rx_dv, .rx_data,
        .go, .word(w), .tx_en, .tx_data, .tx_er, .rx_last, .rx_cnt);
    function automatic logic [11:0] exp_st(input mpsi_pkg::mpsi_strap_t q);
        logic [1:0] m;
        m = (q.op_mode == 3'h0) ? 2'h0 : (q.op_mode == 3'h2) ? 2'h1 :
            (q.op_mode == 3'h6) ? 2'h2 : 2'h3;
        return {q.tree_sel, q.speed, q.strap_a, q.duplex, m, q.op_mode,
            q.addr};
    endfunction : exp_st
    task report_and_stop;
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, penable} <= 2'b10;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && k++ < 20);
        if (k >= 20)
            fail_count++;
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task rst(input mpsi_pkg::mpsi_strap_t q);
        @(posedge pclk);
        presetn <= 1'b0;
        s <= q;
        repeat (16) @(posedge pclk);
        `CHK("in_reset", 2'b10, {rx_data_oe_n, tx_clk});
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : rst
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial
    begin
        #1000000;
        fail_count++;
        report_and_stop();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, go, w, s} = '0;
        {presetn, line_link_up, line_energy, fail_count, cmp_count} = '0;
        void'($urandom(32'hd148));
        for (int i = 0; i < 8; i++)
        begin
            t = 10'($urandom);
            t.op_mode = 3'(i);
            rst(t);
            apb(1'b0, mpsi_pkg::ADDR_STATUS, 32'h0);
            `CHK("status", exp_st(t), r[11:0]);
            apb(1'b0, mpsi_pkg::ADDR_CTRL0, 32'h0);
            `CHK("ctrl0", {2'h0, t.speed, t.strap_a, 3'h0, ~t.duplex, 8'h0},
                r[15:0]);
            apb(1'b0, mpsi_pkg::ADDR_ADV, 32'h0);
            `CHK("adv", {8'h0, t.speed, 7'h0}, r[15:0]);
        end
        apb(1'b1, 8'h24, 32'hFFFFFFFF);
        apb(1'b0, 8'h24, 32'h0);
        `CHK("unmapped", 33'h100000000, {e, r});
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, mpsi_pkg::ADDR_IRQ_ENABLE, k ? 32'h0 : 32'h4);
            x = $urandom;
            c = rx_cnt;
            apb(1'b1, mpsi_pkg::ADDR_RX_DATA, x);
            n = 0;
            while (rx_cnt === c && n++ < 40) @(posedge pclk);
            `CHK("rx_nibble", x[3:0], rx_last);
            `CHK("irq", k ? 1'b0 : 1'b1, irq);
            apb(1'b1, mpsi_pkg::ADDR_IRQ_CLEAR, 32'hF);
            repeat (2) @(posedge pclk);
            `CHK("irq_clear", 1'b0, irq);
            w <= {k[0], 4'($urandom)};
            go <= 1'b1;
            n = 0;
            do apb(1'b0, mpsi_pkg::ADDR_IRQ_STATUS, 32'h0);
            while (r[0] !== 1'b1 && n++ < 20);
            go <= 1'b0;
            `CHK("tx_irq", {k[0], 1'b1}, r[1:0]);
            apb(1'b0, mpsi_pkg::ADDR_TX_DATA, 32'h0);
            `CHK("tx_word", w, r[4:0]);
            apb(1'b1, mpsi_pkg::ADDR_IRQ_CLEAR, 32'hF);
        end
        line_energy <= 1'b1;
        line_link_up <= 1'b1;
        repeat (8) @(posedge pclk);
        `CHK("pins", {2'b10, ~t.speed}, {line_signal_detect,
            activity_indicator_n, speed_indicator_n});
        report_and_stop();
    end
endmodule : mpsi_top_tb_top
